// ===== common/bcp_defines.svh
// Constants for the brushless commutation and protection block
// Notes on behaviour
// (RULE1) Hall codes 101,100,110,010,011,001 each switch on one documented top/bottom pair.
// (RULE2) Single speed pulse copies hall_u; triple pulse is high for 101,110,011,111; 000/111 all off.
// (RULE3) PWM on-time comes from comparing the speed command with an internal sawtooth ramp.
// (RULE4) Only the bottom arms are chopped; top arms follow the Hall code unchopped.
// (RULE5) Current limit latches all bottom arms off until the next ramp period start.
// (RULE6) Over-current turns all arms off until the recovery time has elapsed.
// (RULE7) Undervoltage turns all arms off until the detector reports the release level.
// (RULE8) A speed command below the all-off threshold turns every arm off.
// (RULE9) Between all-off and sawtooth low only top arms drive; above it both groups drive.
// (RULE10) Triple pulse stuck for the lock detect time turns all arms off for the release time.
// (RULE11) Lock detect and release times scale linearly with the lock capacitor from 1000 pF.
// (RULE12) Lock detection is suppressed at low command, undervoltage or over-temperature.
// (RULE13) Over-temperature turns all arms off until the detector reports the release point.
// (RULE14) The system picks a lock capacitor whose detect time exceeds motor start-up time.
// (RULE15) Bottom gate pulses shorter than the minimum pulse width are rejected.
// (RULE16) All shutdown sources are ORed and override commutation; comparators are synchronised.
// (RULE17) After reset all gates stay off until synchronised inputs are valid.
`ifndef BCP_DEFINES_SVH
`define BCP_DEFINES_SVH

// Timing
`define BCP_CLK_NS            25
`define BCP_MINB_NS           800
`define BCP_MINB_CYC          ((`BCP_MINB_NS + `BCP_CLK_NS - 1) / `BCP_CLK_NS)
`define BCP_OC_RECOVERY_NS    1000000
`define BCP_LOCK_DETECT_US    2000
`define BCP_LOCK_RELEASE_US   12000
`define BCP_LOCK_REF_PF       1000
`define BCP_RAMP_DIV_LAST     4'hE
`define BCP_READY_LAST        2'h3

// Speed command codes, 25 mV per step
`define BCP_CMD_ALL_OFF       8'h31
`define BCP_CMD_SAW_LOW       8'h54
`define BCP_CMD_LOCK_MIN      8'h58
`define BCP_CMD_SAW_TOP       8'hD7

// Register offsets
`define BCP_REG_CTRL          8'h00
`define BCP_REG_STATUS        8'h04
`define BCP_REG_MASK          8'h08
`define BCP_REG_STATE         8'h0C

// Control fields and reset
`define BCP_CTRL_DRIVE_EN     0
`define BCP_CTRL_LOCK_EN      1
`define BCP_CTRL_RST          2'h3

// Status and mask bits
`define BCP_EV_LIMIT          0
`define BCP_EV_OVERCURRENT    1
`define BCP_EV_UNDERVOLT      2
`define BCP_EV_OVERTEMP       3
`define BCP_EV_LOCK           4
`define BCP_EV_WIDTH          5

`endif

// ===== common/bcp_pkg.sv
// Types for the brushless commutation and protection block
package bcp_pkg;
   typedef enum logic [1:0] {
      BCP_OC_RUN  = 2'b01,
      BCP_OC_TRIP = 2'b10
   } bcp_oc_type;

   typedef enum logic [1:0] {
      BCP_LK_WATCH = 2'b01,
      BCP_LK_HOLD  = 2'b10
   } bcp_lock_type;
endpackage

// ===== common/bcp_timer_if.sv
// Control and completion signals of one timeout counter
`timescale 1ns/100ps
interface bcp_timer_if;
   logic        clear;
   logic        run;
   logic [31:0] limit;
   logic        done;
   modport ctl (output clear, output run, output limit, input done);
   modport tmr (input clear, input run, input limit, output done);
endinterface

// ===== src/bcp_timer.sv
// Saturating timeout counter
`timescale 1ns/100ps
module bcp_timer (
   input  wire logic   i_mclk,
   input  wire logic   i_rstn,
   bcp_timer_if.tmr    t
);
   logic [31:0] count_q;

   always_ff @(posedge i_mclk) begin
      if (!i_rstn || t.clear) begin
         count_q <= 32'h0000_0000;
      end else if (t.run && count_q != t.limit) begin
         count_q <= count_q + 32'h0000_0001;
      end
   end

   assign t.done = (count_q == t.limit);

   property p_timer_restart;
      @(posedge i_mclk) disable iff (!i_rstn)
      (t.clear && t.limit != 32'h0000_0000 && $stable(t.limit)) |=> !t.done;
   endproperty
   a_timer_restart: assert property (p_timer_restart) else $error("timer done after clear");
endmodule

// ===== src/bcp_pulse_filter.sv
// Minimum on-width filter for one bottom gate
`timescale 1ns/100ps
`include "bcp_defines.svh"
module bcp_pulse_filter (
   input  wire logic i_mclk,
   input  wire logic i_rstn,
   input  wire logic i_req,
   output logic      o_gate
);
   logic [5:0] cnt_q;

   // Turn-off is immediate, turn-on waits out the minimum width
   always_ff @(posedge i_mclk) begin
      if (!i_rstn || !i_req) begin
         cnt_q  <= 6'h00;
         o_gate <= 1'b0;
      end else if (cnt_q == 6'(`BCP_MINB_CYC - 1)) begin
         o_gate <= 1'b1; // see RULE15
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   property p_min_width;
      @(posedge i_mclk) disable iff (!i_rstn)
      $rose(o_gate) |-> $past(i_req, 1) && $past(i_req, 31);
   endproperty
   a_min_width: assert property (p_min_width) else $error("short bottom pulse passed"); // see RULE15

   property p_fast_off;
      @(posedge i_mclk) disable iff (!i_rstn)
      !i_req |=> !o_gate;
   endproperty
   a_fast_off: assert property (p_fast_off) else $error("bottom gate not released"); // see RULE15
endmodule

// ===== src/bcp_top.sv
// Commutation, PWM and protection for a three-phase brushless bridge
`timescale 1ns/100ps
`include "bcp_defines.svh"
module bcp_top #(
   parameter int OC_RECOVERY_CYC  = `BCP_OC_RECOVERY_NS / `BCP_CLK_NS,
   parameter int LOCK_CAP_PF      = `BCP_LOCK_REF_PF,
   parameter int LOCK_DETECT_CYC  =
      ((`BCP_LOCK_DETECT_US * 1000) / `BCP_CLK_NS) * LOCK_CAP_PF / `BCP_LOCK_REF_PF,
   parameter int LOCK_RELEASE_CYC =
      ((`BCP_LOCK_RELEASE_US * 1000) / `BCP_CLK_NS) * LOCK_CAP_PF / `BCP_LOCK_REF_PF
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   input  wire logic        i_hall_u,
   input  wire logic        i_hall_v,
   input  wire logic        i_hall_w,
   input  wire logic [7:0]  i_speed_command,
   input  wire logic        i_limit_cmp,
   input  wire logic        i_overcurrent_cmp,
   input  wire logic        i_undervoltage,
   input  wire logic        i_overtemp,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic [2:0]       o_phase_top,
   output logic [2:0]       o_phase_bottom,
   output logic             o_speed_pulse_single,
   output logic             o_speed_pulse_triple,
   output logic             o_irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Decoders

   // Returns {top u,v,w, bottom u,v,w}
   function automatic logic [5:0] bcp_commutate(input logic [2:0] code);
      logic [5:0] sel;
      sel = 6'h00;
      unique case (code)
         3'h5:    sel = 6'b010_100;
         3'h4:    sel = 6'b001_100;
         3'h6:    sel = 6'b001_010;
         3'h2:    sel = 6'b100_010;
         3'h3:    sel = 6'b100_001;
         3'h1:    sel = 6'b010_001;
         default: sel = 6'h00;
      endcase
      return sel;
   endfunction

   function automatic logic bcp_reg_hit(input logic [7:0] addr);
      return addr == `BCP_REG_CTRL || addr == `BCP_REG_STATUS ||
             addr == `BCP_REG_MASK || addr == `BCP_REG_STATE;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and start-up

   logic [6:0] sync1_q;
   logic [6:0] sync2_q;
   logic [2:0] hall_s;
   logic       limit_s;
   logic       oc_s;
   logic       uv_s;
   logic       ot_s;
   logic [1:0] ready_cnt_q;
   logic       ready_q;

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
      end else begin
         sync1_q <= {i_hall_u, i_hall_v, i_hall_w, i_limit_cmp, i_overcurrent_cmp,
                     i_undervoltage, i_overtemp}; // see RULE16
         sync2_q <= sync1_q;
      end
   end

   assign hall_s  = sync2_q[6:4];
   assign limit_s = sync2_q[3];
   assign oc_s    = sync2_q[2];
   assign uv_s    = sync2_q[1];
   assign ot_s    = sync2_q[0];

   // Gates held off until the synchroniser pipe has filled
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         ready_cnt_q <= 2'h0;
         ready_q     <= 1'b0;
      end else if (ready_cnt_q == `BCP_READY_LAST) begin
         ready_q <= 1'b1; // see RULE17
      end else begin
         ready_cnt_q <= ready_cnt_q + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sawtooth ramp and PWM compare

   logic [3:0] div_q;
   logic       step;
   logic [7:0] ramp_q;
   logic       period_start;
   logic       pwm_on;

   assign step         = (div_q == `BCP_RAMP_DIV_LAST);
   assign period_start = step && (ramp_q == `BCP_CMD_SAW_TOP);
   assign pwm_on       = (i_speed_command > ramp_q); // see RULE3

   always_ff @(posedge i_mclk) begin
      if (!i_rstn || step) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn || period_start) begin
         ramp_q <= `BCP_CMD_SAW_LOW;
      end else if (step) begin
         ramp_q <= ramp_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Current limit latch

   logic climit_q;

   always_ff @(posedge i_mclk) begin
      if (!i_rstn || !ready_q) begin
         climit_q <= 1'b0;
      end else if (limit_s) begin
         climit_q <= 1'b1; // see RULE5
      end else if (period_start) begin
         climit_q <= 1'b0; // see RULE5
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Over-current trip and recovery

   bcp_timer_if        oc_tmr ();
   bcp_pkg::bcp_oc_type oc_q;

   assign oc_tmr.clear = (oc_q == bcp_pkg::BCP_OC_RUN) || oc_tmr.done;
   assign oc_tmr.run   = (oc_q == bcp_pkg::BCP_OC_TRIP);
   assign oc_tmr.limit = 32'(OC_RECOVERY_CYC);

   bcp_timer u_oc_timer (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .t      (oc_tmr)
   );

   always_ff @(posedge i_mclk) begin
      if (!i_rstn || !ready_q) begin
         oc_q <= bcp_pkg::BCP_OC_RUN;
      end else begin
         unique case (oc_q)
            bcp_pkg::BCP_OC_RUN: begin
               if (oc_s) begin
                  oc_q <= bcp_pkg::BCP_OC_TRIP; // see RULE6
               end
            end
            bcp_pkg::BCP_OC_TRIP: begin
               if (oc_tmr.done) begin
                  oc_q <= bcp_pkg::BCP_OC_RUN; // see RULE6
               end
            end
            default: oc_q <= bcp_pkg::BCP_OC_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Commutation and motor lock

   logic [5:0]           comm;
   logic                 triple_c;
   logic                 lock_suppress;
   logic [1:0]           ctrl_q;
   bcp_timer_if          lk_tmr ();
   bcp_pkg::bcp_lock_type lk_q;

   assign comm     = bcp_commutate(hall_s); // see RULE1
   assign triple_c = (hall_s[2] & hall_s[1]) | (hall_s[1] & hall_s[0]) |
                     (hall_s[2] & hall_s[0]); // see RULE2
   assign lock_suppress = (i_speed_command <= `BCP_CMD_LOCK_MIN) || uv_s || ot_s ||
                          !ctrl_q[`BCP_CTRL_LOCK_EN]; // see RULE12

   assign lk_tmr.clear = ((lk_q == bcp_pkg::BCP_LK_WATCH) &&
                          (lock_suppress || triple_c != o_speed_pulse_triple)) ||
                         lk_tmr.done; // see RULE10
   assign lk_tmr.run   = 1'b1;
   assign lk_tmr.limit = (lk_q == bcp_pkg::BCP_LK_HOLD) ? 32'(LOCK_RELEASE_CYC) :
                                                          32'(LOCK_DETECT_CYC); // see RULE11

   bcp_timer u_lock_timer (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .t      (lk_tmr)
   );

   always_ff @(posedge i_mclk) begin
      if (!i_rstn || !ready_q) begin
         lk_q <= bcp_pkg::BCP_LK_WATCH;
      end else begin
         unique case (lk_q)
            bcp_pkg::BCP_LK_WATCH: begin
               if (lk_tmr.done && !lock_suppress) begin
                  lk_q <= bcp_pkg::BCP_LK_HOLD; // see RULE10 RULE12
               end
            end
            bcp_pkg::BCP_LK_HOLD: begin
               if (lk_tmr.done) begin
                  lk_q <= bcp_pkg::BCP_LK_WATCH; // see RULE10
               end
            end
            default: lk_q <= bcp_pkg::BCP_LK_WATCH;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gate drive

   logic       all_off;
   logic       bottom_block;
   logic [2:0] bottom_req;

   assign all_off = !ready_q || (oc_q == bcp_pkg::BCP_OC_TRIP) || uv_s || ot_s ||
                    (lk_q == bcp_pkg::BCP_LK_HOLD) ||
                    (i_speed_command < `BCP_CMD_ALL_OFF) ||
                    !ctrl_q[`BCP_CTRL_DRIVE_EN]; // see RULE16 RULE6 RULE7 RULE8 RULE13 RULE17
   assign bottom_block = all_off || (i_speed_command < `BCP_CMD_SAW_LOW) ||
                         climit_q || !pwm_on; // see RULE9 RULE5
   assign bottom_req = bottom_block ? 3'h0 : comm[2:0]; // see RULE4

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_phase_top          <= 3'h0;
         o_speed_pulse_single <= 1'b0;
         o_speed_pulse_triple <= 1'b0;
      end else begin
         o_phase_top          <= all_off ? 3'h0 : comm[5:3]; // see RULE4 RULE9
         o_speed_pulse_single <= hall_s[2]; // see RULE2
         o_speed_pulse_triple <= triple_c;
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_bottom
      bcp_pulse_filter u_filter (
         .i_mclk (i_mclk),
         .i_rstn (i_rstn),
         .i_req  (bottom_req[g]),
         .o_gate (o_phase_bottom[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and interrupt

   logic [`BCP_EV_WIDTH-1:0] levels;
   logic [`BCP_EV_WIDTH-1:0] levels_q;
   logic [`BCP_EV_WIDTH-1:0] status_q;
   logic [`BCP_EV_WIDTH-1:0] mask_q;
   logic [`BCP_EV_WIDTH-1:0] w1c;
   logic                     wr_en;
   logic [31:0]              rd_mux;

   assign levels = {lk_q == bcp_pkg::BCP_LK_HOLD, ot_s, uv_s,
                    oc_q == bcp_pkg::BCP_OC_TRIP, climit_q};
   assign wr_en  = i_psel && i_penable && i_pwrite && bcp_reg_hit(i_paddr);
   assign w1c    = (wr_en && i_paddr == `BCP_REG_STATUS) ? i_pwdata[`BCP_EV_WIDTH-1:0] :
                                                          5'h00;
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !bcp_reg_hit(i_paddr);

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         ctrl_q <= `BCP_CTRL_RST;
         mask_q <= 5'h00;
      end else if (wr_en && i_paddr == `BCP_REG_CTRL) begin
         ctrl_q <= i_pwdata[1:0];
      end else if (wr_en && i_paddr == `BCP_REG_MASK) begin
         mask_q <= i_pwdata[`BCP_EV_WIDTH-1:0];
      end
   end

   // New events win over a same-cycle clear
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         levels_q <= 5'h00;
         status_q <= 5'h00;
         o_irq    <= 1'b0;
      end else begin
         levels_q <= levels;
         status_q <= (status_q & ~w1c) | (levels & ~levels_q);
         o_irq    <= |(status_q & mask_q);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_paddr)
         `BCP_REG_CTRL:   rd_mux = {30'h0, ctrl_q};
         `BCP_REG_STATUS: rd_mux = {27'h0, status_q};
         `BCP_REG_MASK:   rd_mux = {27'h0, mask_q};
         `BCP_REG_STATE:  rd_mux = {17'h0, ready_q, o_phase_bottom, o_phase_top,
                                    levels, hall_s};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup cycle
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable) begin
         o_prdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_comm_pair;
      @(posedge i_mclk) disable iff (!i_rstn)
      (!all_off && hall_s == 3'h5) |=> o_phase_top == 3'b010;
   endproperty
   a_comm_pair: assert property (p_comm_pair) else $error("top pair wrong for code 101"); // see RULE1

   property p_triple;
      @(posedge i_mclk) disable iff (!i_rstn)
      (hall_s == 3'h5 ##1 hall_s == 3'h4) |-> o_speed_pulse_triple ##1 !o_speed_pulse_triple;
   endproperty
   a_triple: assert property (p_triple) else $error("triple pulse level wrong"); // see RULE2

   property p_dead_code;
      @(posedge i_mclk) disable iff (!i_rstn)
      (hall_s == 3'h7 || hall_s == 3'h0) |=> o_phase_top == 3'h0 ##1 o_phase_bottom == 3'h0;
   endproperty
   a_dead_code: assert property (p_dead_code) else $error("gates on for invalid code"); // see RULE2

   property p_limit_off;
      @(posedge i_mclk) disable iff (!i_rstn)
      climit_q |=> o_phase_bottom == 3'h0;
   endproperty
   a_limit_off: assert property (p_limit_off) else $error("bottom on under limit"); // see RULE5

   property p_oc_hold;
      @(posedge i_mclk) disable iff (!i_rstn)
      (oc_q == bcp_pkg::BCP_OC_RUN && oc_s && ready_q) |=>
         (oc_q == bcp_pkg::BCP_OC_TRIP)[*8] ##0 o_phase_top == 3'h0;
   endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("over-current hold broken"); // see RULE6

   property p_fault_off;
      @(posedge i_mclk) disable iff (!i_rstn)
      (uv_s || ot_s) |=> o_phase_top == 3'h0 ##1 o_phase_bottom == 3'h0;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("gates on under fault"); // see RULE7 RULE13

   property p_stop_band;
      @(posedge i_mclk) disable iff (!i_rstn)
      (i_speed_command < `BCP_CMD_SAW_LOW) |=> o_phase_bottom == 3'h0;
   endproperty
   a_stop_band: assert property (p_stop_band) else $error("bottom on below ramp low"); // see RULE9

   property p_all_off_cmd;
      @(posedge i_mclk) disable iff (!i_rstn)
      (i_speed_command < `BCP_CMD_ALL_OFF) |=> o_phase_top == 3'h0;
   endproperty
   a_all_off_cmd: assert property (p_all_off_cmd) else $error("top on below all-off"); // see RULE8

   property p_lock_suppress;
      @(posedge i_mclk) disable iff (!i_rstn)
      (lk_q == bcp_pkg::BCP_LK_WATCH && lock_suppress) |=> lk_q == bcp_pkg::BCP_LK_WATCH;
   endproperty
   a_lock_suppress: assert property (p_lock_suppress) else $error("lock while suppressed"); // see RULE12

   property p_lock_off;
      @(posedge i_mclk) disable iff (!i_rstn)
      (lk_q == bcp_pkg::BCP_LK_HOLD) |=> o_phase_top == 3'h0;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("top on while locked"); // see RULE10

   property p_reset_off;
      @(posedge i_mclk) disable iff (!i_rstn)
      !ready_q |=> o_phase_top == 3'h0 && o_phase_bottom == 3'h0;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("gates on before ready"); // see RULE17
endmodule

// ===== verif/bcp_hall_model.sv
// Hall sensor model that holds a code or spins through the six states
`timescale 1ns/100ps
module bcp_hall_model #(
   parameter int SPIN_CYC = 20
) (
   input  wire logic       i_mclk,
   input  wire logic       i_spin,
   input  wire logic [2:0] i_code,
   output logic            o_hall_u,
   output logic            o_hall_v,
   output logic            o_hall_w
);
   logic [2:0] seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   int         step_q  = 0;
   int         cnt_q   = 0;

   // Spin step kept far shorter than the lock detect time
   always_ff @(posedge i_mclk) begin
      cnt_q <= (cnt_q == SPIN_CYC - 1) ? 0 : cnt_q + 1;
      if (i_spin && cnt_q == SPIN_CYC - 1) begin
         step_q <= (step_q + 1) % 6;
      end
   end

   assign {o_hall_u, o_hall_v, o_hall_w} = i_spin ? seq[step_q] : i_code;
endmodule

// ===== verif/bcp_top_test.sv
// Self-checking bench for the commutation and protection block
`timescale 1ns/100ps
module bcp_top_test;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        spin = 1'b0;
   logic [2:0]  code = 3'h5;
   logic [7:0]  cmd = 8'hFF;
   logic [7:0]  paddr = 8'h00;
   logic [3:0]  flt = 4'h0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic        pready, perr, e, hu, hv, hw, single, triple, irq;
   logic [2:0]  top, bot;
   logic [7:0]  trip = 8'hE8;
   logic [5:0]  tbl [8] = '{6'h00, 6'h11, 6'h22, 6'h21, 6'h0C, 6'h14, 6'h0A, 6'h00};
   logic [7:0]  bc [4] = '{8'h30, 8'h31, 8'h53, 8'hFF};
   logic [5:0]  bx [4] = '{6'h00, 6'h10, 6'h10, 6'h14};
   int          n_fail = 0;
   int          checks_done = 0;
   int          n;

   bcp_hall_model hall_u0 (.i_mclk(clk), .i_spin(spin), .i_code(code),
                           .o_hall_u(hu), .o_hall_v(hv), .o_hall_w(hw));

   bcp_top #(.OC_RECOVERY_CYC(50), .LOCK_DETECT_CYC(100), .LOCK_RELEASE_CYC(200)) dut_u (
      .i_mclk(clk), .i_rstn(rstn), .i_hall_u(hu), .i_hall_v(hv), .i_hall_w(hw),
      .i_speed_command(cmd), .i_limit_cmp(flt[0]), .i_overcurrent_cmp(flt[1]),
      .i_undervoltage(flt[2]), .i_overtemp(flt[3]), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(perr), .o_phase_top(top), .o_phase_bottom(bot),
      .o_speed_pulse_single(single), .o_speed_pulse_triple(triple), .o_irq(irq));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      chk("reset_gates", 32'({top, bot}), 32'h0);
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", q, 32'h3);
      chk("ctrl_err", 32'(e), 32'h0);
      chk("pready", 32'(pready), 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk("mask", q, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped_err", 32'(e), 32'h1);
      chk("unmapped_data", q, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         code <= 3'(c);
         repeat (40) @(posedge clk);
         chk("gates", 32'({top, bot}), 32'(tbl[c]));
         chk("single", 32'(single), 32'(c[2]));
         chk("triple", 32'(triple), 32'(trip[c]));
      end
      code <= 3'h5;
      $display("test commutation done");
      for (int i = 0; i < 4; i++) begin
         cmd <= bc[i];
         repeat (40) @(posedge clk);
         chk("band", 32'({top, bot}), 32'(bx[i]));
      end
      apb(1'b0, 8'h0C, 32'h0);
      chk("state", q, 32'h0000_6205);
      $display("test speed bands done");
      for (int i = 0; i < 2; i++) begin
         cmd <= i == 0 ? 8'h95 : 8'h56;
         repeat (2000) @(posedge clk);
         n = 0;
         repeat (1980) begin
            @(negedge clk);
            n += int'(bot[2]);
         end
         @(posedge clk);
         chk("pwm_on", 32'(i == 0 ? (n >= 930 && n <= 975) : (n == 0)), 32'h1);
      end
      cmd <= 8'hFF;
      repeat (100) @(posedge clk);
      $display("test pwm done");
      for (int i = 0; i < 4; i++) begin
         flt[i] <= 1'b1;
         repeat (10) @(posedge clk);
         chk("fault_gates", 32'({top, bot}), i == 0 ? 32'h10 : 32'h0);
         chk("irq_masked", 32'(irq), 32'h0);
         flt[i] <= 1'b0;
         repeat (10) @(posedge clk);
         chk("hold_top", 32'(top), i == 1 ? 32'h0 : 32'h2);
         apb(1'b1, 8'h08, 32'h1F);
         repeat (3) @(posedge clk);
         chk("irq", 32'(irq), 32'h1);
         apb(1'b0, 8'h04, 32'h0);
         chk("status", q, 32'h1 << i);
         apb(1'b1, 8'h04, 32'h1F);
         repeat (3) @(posedge clk);
         chk("irq_clear", 32'(irq), 32'h0);
         apb(1'b1, 8'h08, 32'h0);
         repeat (2100) @(posedge clk);
         chk("recovered", 32'({top, bot}), 32'h14);
      end
      $display("test faults done");
      apb(1'b1, 8'h00, 32'h3);
      cmd <= 8'h57;
      repeat (300) @(posedge clk);
      chk("lock_low_cmd", 32'(top), 32'h2);
      cmd <= 8'hFF;
      spin <= 1'b1;
      repeat (400) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      chk("no_lock_spin", 32'(q[4]), 32'h0);
      spin <= 1'b0;
      repeat (60) @(posedge clk);
      chk("lock_wait", 32'(top), 32'h2);
      repeat (90) @(posedge clk);
      chk("lock_off", 32'({top, bot}), 32'h0);
      repeat (180) @(posedge clk);
      chk("lock_release", 32'(top), 32'h2);
      apb(1'b0, 8'h04, 32'h0);
      chk("lock_status", 32'(q[4]), 32'h1);
      $display("test lock done");
      print_verdict();
   end
endmodule
